/* include/flow_exec_pkg.sv */
// Package for the control-flow and direct-load execution unit.
// Assumes an 8-bit core with a 22-bit word program counter.
package flow_exec_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int PC_W    = 22;   // Program counter width in words
  localparam int DADDR_W = 16;   // Data-space address width
  localparam int NREGS   = 32;   // General registers

  // ****************************************************************
  // Flag positions inside flags_reg
  // ****************************************************************
  localparam logic [2:0] FLAG_C = 3'h0;  // Carry
  localparam logic [2:0] FLAG_Z = 3'h1;  // Zero
  localparam logic [2:0] FLAG_N = 3'h2;  // Negative
  localparam logic [2:0] FLAG_V = 3'h3;  // Overflow
  localparam logic [2:0] FLAG_S = 3'h4;  // Sign, tested as N xor V
  localparam logic [2:0] FLAG_H = 3'h5;  // Half carry
  localparam logic [2:0] FLAG_T = 3'h6;  // Transfer bit
  localparam logic [2:0] FLAG_I = 3'h7;  // Global interrupt enable

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [PC_W-1:0] PC_RST    = 22'h000000;
  localparam logic [7:0]      FLAGS_RST = 8'h00;

  // ****************************************************************
  // Opcode patterns: value and mask
  // ****************************************************************
  localparam logic [15:0] OP_EXT_INDIRECT_JSR = 16'h9519;
  localparam logic [15:0] OP_RET    = 16'h9508;
  localparam logic [15:0] OP_IRQ_EXIT   = 16'h9518;
  localparam logic [15:0] MK_RR     = 16'hfc00;  // Two-register forms
  localparam logic [15:0] OP_EQUAL_COMPARE_SKIP   = 16'h1000;
  localparam logic [15:0] OP_CP     = 16'h1400;
  localparam logic [15:0] OP_CPC    = 16'h0400;
  localparam logic [15:0] MK_CPI    = 16'hf000;
  localparam logic [15:0] OP_CPI    = 16'h3000;
  localparam logic [15:0] MK_RBIT   = 16'hfe08;
  localparam logic [15:0] OP_RBC    = 16'hfc00;
  localparam logic [15:0] OP_RBS    = 16'hfe00;
  localparam logic [15:0] MK_IOBIT  = 16'hff00;
  localparam logic [15:0] OP_IOC    = 16'h9900;
  localparam logic [15:0] OP_IOS    = 16'h9b00;
  localparam logic [15:0] OP_BRS    = 16'hf000;  // Uses MK_RR
  localparam logic [15:0] OP_BRC    = 16'hf400;  // Uses MK_RR
  localparam logic [15:0] MK_LDST   = 16'hfe0f;
  localparam logic [15:0] OP_LDS    = 16'h9000;
  localparam logic [15:0] OP_STS    = 16'h9200;
  localparam logic [15:0] MK_JC     = 16'hfe0c;
  localparam logic [15:0] OP_JC     = 16'h940c;  // Long jump or call

  // ****************************************************************
  // Timing counts: cycles spent in ST_WAIT, less one; totals noted
  // ****************************************************************
  localparam logic [1:0] STALL_BRANCH = 2'h0;  // Taken branch: 2
  localparam logic [1:0] STALL_ICALL  = 2'h1;  // Indirect call: 3
  localparam logic [1:0] STALL_RET    = 2'h1;  // Return: 4

  // ****************************************************************
  // Sequencer states, Gray-coded in the order listed
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_RUN    = 3'h0,
    ST_SKIP1  = 3'h1,
    ST_SKIP2  = 3'h3,
    ST_WAIT   = 3'h2,
    ST_IOWAIT = 3'h6,
    ST_LDADDR = 3'h7,
    ST_LDDATA = 3'h5,
    ST_POP    = 3'h4
  } seq_state_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic               rd;    // Read request, held until ack
    logic [DADDR_W-1:0] addr;  // Data-space address
  } mem_req_t;

  typedef struct packed {
    logic       rd;    // One-cycle I/O read strobe
    logic [4:0] addr;  // I/O register address
  } io_req_t;

  typedef struct packed {
    logic            push;   // One-cycle push strobe
    logic            pop;    // One-cycle pop strobe
    logic [PC_W-1:0] wdata;  // Return address to push
  } stack_req_t;

endpackage

/* src/cmp_flags.sv */
// Compare flag unit: subtracts without storing and forms new flags.
// Assumes the caller merges the result into flags_reg.
`timescale 1ns/1ps
`default_nettype none
module cmp_flags
(
  // Operands
  input  wire logic [7:0] a_i,       // Minuend register
  input  wire logic [7:0] b_i,       // Subtrahend register or constant
  input  wire logic       use_c_i,   // Subtract carry too, chain zero
  input  wire logic [7:0] flags_i,   // Current flags
  // Result
  output logic      [7:0] flags_o    // Flags after the compare
);
  import flow_exec_pkg::*;

  logic [7:0] res;   // Difference, never written back
  logic       cin;   // Borrow in
  logic       v;     // Signed overflow

  // ****************************************************************
  // Difference and flags
  // ****************************************************************
  always_comb
  begin
    cin = use_c_i & flags_i[FLAG_C];
    res = a_i - b_i - {7'h00, cin};
    v   = (a_i[7] & ~b_i[7] & ~res[7]) | (~a_i[7] & b_i[7] & res[7]);
    flags_o = flags_i;                                       // RQ14
    flags_o[FLAG_H] = (~a_i[3] & b_i[3]) | (b_i[3] & res[3])
                      | (res[3] & ~a_i[3]);                  // RQ14
    flags_o[FLAG_C] = (~a_i[7] & b_i[7]) | (b_i[7] & res[7])
                      | (res[7] & ~a_i[7]);                  // RQ14
    flags_o[FLAG_N] = res[7];                                // RQ14
    flags_o[FLAG_V] = v;                                     // RQ14
    flags_o[FLAG_S] = res[7] ^ v;                            // RQ14
    // Chained compare may only keep Z set, so long compares work
    if (use_c_i)
    begin
      flags_o[FLAG_Z] = (res == 8'h00) & flags_i[FLAG_Z];    // RQ14
    end
    else
    begin
      flags_o[FLAG_Z] = (res == 8'h00);                      // RQ14
    end
  end

endmodule
`default_nettype wire

/* src/flow_exec.sv */
// Execution unit for calls, returns, skips, branches and direct loads.
// Assumes program memory answers combinationally at pmem_addr_o,
// a stack that answers a pop in the cycle its strobe is up, and a data space
// that answers a held read with a one-cycle ack.
// Summary of operation
// (RQ1) Indirect call: PC from Z and high byte
// (RQ2) Skip next instruction when two registers equal
// (RQ3) Skip on register bit clear or set
// (RQ4) Skip on I/O bit, two to four cycles
// (RQ5) Flag branch to PC+k+1, one or two
// (RQ6) Named branches test Z, C or N
// (RQ7) Signed branches test N xor V
// (RQ8) Unsigned branches test carry only
// (RQ9) Interrupt branches test the I flag
// (RQ10) Half-carry branches test H
// (RQ11) Overflow branches test V
// (RQ12) Transfer-bit branches test T
// (RQ13) Direct load copies data byte, flags kept
// (RQ14) Compares set flags, write no register
// (RQ15) Returns pop PC; interrupt return sets I
`timescale 1ns/1ps
`default_nettype none
module flow_exec
(
  // Clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      sys_rst_i,
  // Program memory
  output logic [flow_exec_pkg::PC_W-1:0] pmem_addr_o,
  input  wire logic [15:0]               pmem_data_i,
  // Far-target high byte from the I/O space
  input  wire logic [7:0]                far_target_high_byte_i,
  // Data space read
  output flow_exec_pkg::mem_req_t        mem_req_o,
  input  wire logic                      mem_ack_i,
  input  wire logic [7:0]                mem_rdata_i,
  // I/O bit read
  output flow_exec_pkg::io_req_t         io_req_o,
  input  wire logic [7:0]                io_rdata_i,
  // Stack
  output flow_exec_pkg::stack_req_t      stack_req_o,
  input  wire logic [flow_exec_pkg::PC_W-1:0] stack_rdata_i,
  // Register file and flags access from the rest of the core
  input  wire logic                      rf_we_i,
  input  wire logic [4:0]                rf_waddr_i,
  input  wire logic [7:0]                rf_wdata_i,
  input  wire logic [4:0]                rf_raddr_i,
  output logic [7:0]                     rf_rdata_o,
  input  wire logic                      flags_we_i,
  input  wire logic [7:0]                flags_wdata_i,
  // Status
  output logic [flow_exec_pkg::PC_W-1:0] pc_o,
  output logic [7:0]                     flags_reg_o,
  output logic                           unsup_o
);
  import flow_exec_pkg::*;

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    seq_state_t           st;      // Sequencer state
    logic [PC_W-1:0]      pc;      // Program counter
    logic [7:0]           flags;   // flags_reg
    logic [NREGS-1:0][7:0] rf;     // General registers
    logic [1:0]           cnt;     // Remaining stall cycles
    logic [4:0]           ld_dst;  // Direct-load destination
    logic [2:0]           io_bit;  // Bit under test for I/O skip
    logic                 io_set;  // I/O skip on set bit
    mem_req_t             mem;     // Data read request
    io_req_t              io;      // I/O read strobe
    stack_req_t           stk;     // Stack strobes
    logic [7:0]           rf_rd;   // Registered read port
    logic                 unsup;   // Opcode outside this unit
  } exec_state_t;

  exec_state_t s_q;   // Registered state
  exec_state_t s_d;   // Next state

  logic [15:0] ins;        // Instruction word
  logic [7:0]  opa;        // First operand register
  logic [7:0]  opb;        // Second operand
  logic        cmp_c;      // Compare with carry
  logic [7:0]  cmp_out;    // Flags after compare
  logic        flag_bit;   // Selected flag for branches
  logic [PC_W-1:0] br_tgt; // Relative branch target

  // Matches an opcode against a value under a mask
  function automatic logic op_is(input logic [15:0] w,
                                 input logic [15:0] mk,
                                 input logic [15:0] v);
    op_is = (w & mk) == v;
  endfunction

  // Word after a skip is two words long when it carries an address
  function automatic logic two_word(input logic [15:0] w);
    two_word = op_is(w, MK_LDST, OP_LDS) | op_is(w, MK_LDST, OP_STS)
               | op_is(w, MK_JC, OP_JC);
  endfunction

  // ****************************************************************
  // Operand selection and compare unit
  // ****************************************************************
  always_comb
  begin
    ins   = pmem_data_i;
    cmp_c = op_is(ins, MK_RR, OP_CPC);
    if (op_is(ins, MK_CPI, OP_CPI))
    begin
      // Immediate form reaches only the upper sixteen registers
      opa = s_q.rf[{1'b1, ins[7:4]}];
      opb = {ins[11:8], ins[3:0]};
    end
    else
    begin
      opa = s_q.rf[ins[8:4]];
      opb = s_q.rf[{ins[9], ins[3:0]}];
    end
    // Sign flag is tested as N xor V so it tracks loaded flags too
    if (ins[2:0] == FLAG_S)
    begin
      flag_bit = s_q.flags[FLAG_N] ^ s_q.flags[FLAG_V];     // RQ7
    end
    else
    begin
      flag_bit = s_q.flags[ins[2:0]];  // RQ6 RQ8 RQ9 RQ10 RQ11 RQ12
    end
    br_tgt = s_q.pc + {{(PC_W-7){ins[9]}}, ins[9:3]}
             + 22'h000001;                                   // RQ5
  end

  cmp_flags u_cmp
  (
    .a_i     (opa),
    .b_i     (opb),
    .use_c_i (cmp_c),
    .flags_i (s_q.flags),
    .flags_o (cmp_out)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    s_d           = s_q;
    s_d.io.rd     = 1'b0;
    s_d.stk.push  = 1'b0;
    s_d.stk.pop   = 1'b0;
    s_d.unsup     = 1'b0;
    // Outside writes land first so this unit's own writes win
    if (rf_we_i)
    begin
      s_d.rf[rf_waddr_i] = rf_wdata_i;
    end
    if (flags_we_i)
    begin
      s_d.flags = flags_wdata_i;
    end
    case (s_q.st)
      ST_RUN:
      begin
        s_d.pc = s_q.pc + 22'h000001;
        if (ins == OP_EXT_INDIRECT_JSR)
        begin
          // Return address is the word after the call
          s_d.stk.push  = 1'b1;
          s_d.stk.wdata = s_q.pc + 22'h000001;               // RQ1
          s_d.pc = {far_target_high_byte_i[5:0],
                    s_q.rf[31], s_q.rf[30]};                 // RQ1
          s_d.cnt = STALL_ICALL;
          s_d.st  = ST_WAIT;
        end
        else if (ins == OP_RET || ins == OP_IRQ_EXIT)
        begin
          s_d.stk.pop = 1'b1;                                // RQ15
          if (ins == OP_IRQ_EXIT)
          begin
            s_d.flags[FLAG_I] = 1'b1;                        // RQ15
          end
          s_d.st = ST_POP;
        end
        else if (op_is(ins, MK_RR, OP_EQUAL_COMPARE_SKIP))
        begin
          if (opa == opb)
          begin
            s_d.st = ST_SKIP1;                               // RQ2
          end
        end
        else if (op_is(ins, MK_RR, OP_CP) || cmp_c
                 || op_is(ins, MK_CPI, OP_CPI))
        begin
          s_d.flags = cmp_out;                               // RQ14
        end
        else if (op_is(ins, MK_RBIT, OP_RBC)
                 || op_is(ins, MK_RBIT, OP_RBS))
        begin
          if (s_q.rf[ins[8:4]][ins[2:0]] == ins[9])
          begin
            s_d.st = ST_SKIP1;                               // RQ3
          end
        end
        else if (op_is(ins, MK_IOBIT, OP_IOC)
                 || op_is(ins, MK_IOBIT, OP_IOS))
        begin
          // I/O value arrives one cycle later, hence the extra cycle
          s_d.io.rd   = 1'b1;                                // RQ4
          s_d.io.addr = ins[7:3];
          s_d.io_bit  = ins[2:0];
          s_d.io_set  = ins[9];
          s_d.st      = ST_IOWAIT;
        end
        else if (op_is(ins, MK_RR, OP_BRS) || op_is(ins, MK_RR, OP_BRC))
        begin
          // Bit 10 picks the clear variant
          if (flag_bit != ins[10])
          begin
            s_d.pc  = br_tgt;                                // RQ5
            s_d.cnt = STALL_BRANCH;
            s_d.st  = ST_WAIT;
          end
        end
        else if (op_is(ins, MK_LDST, OP_LDS))
        begin
          s_d.ld_dst = ins[8:4];                             // RQ13
          s_d.st     = ST_LDADDR;
        end
        else
        begin
          // Left to other units of the core; step over it here
          s_d.unsup = 1'b1;
        end
      end
      ST_SKIP1:
      begin
        // Discard the skipped word, and its address word if any
        s_d.pc = s_q.pc + 22'h000001;                        // RQ2 RQ3
        s_d.st = two_word(ins) ? ST_SKIP2 : ST_RUN;          // RQ2 RQ3
      end
      ST_SKIP2:
      begin
        s_d.pc = s_q.pc + 22'h000001;
        s_d.st = ST_RUN;
      end
      ST_IOWAIT:
      begin
        s_d.st = (io_rdata_i[s_q.io_bit] == s_q.io_set)
                 ? ST_SKIP1 : ST_RUN;                        // RQ4
      end
      ST_LDADDR:
      begin
        s_d.mem.rd   = 1'b1;                                 // RQ13
        s_d.mem.addr = ins;
        s_d.pc       = s_q.pc + 22'h000001;
        s_d.st       = ST_LDDATA;
      end
      ST_LDDATA:
      begin
        // Wait states come from the data space itself
        if (mem_ack_i)
        begin
          s_d.rf[s_q.ld_dst] = mem_rdata_i;                  // RQ13
          s_d.mem.rd = 1'b0;
          s_d.st     = ST_RUN;
        end
      end
      ST_POP:
      begin
        s_d.pc  = stack_rdata_i;                             // RQ15
        s_d.cnt = STALL_RET;
        s_d.st  = ST_WAIT;
      end
      ST_WAIT:
      begin
        // Fetch is held; the new PC is already in place
        if (s_q.cnt == 2'h0)
        begin
          s_d.st = ST_RUN;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 2'h1;
        end
      end
      default:
      begin
        s_d.st = ST_RUN;
      end
    endcase
    s_d.rf_rd = s_d.rf[rf_raddr_i];
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      s_q       <= '0;
      s_q.st    <= ST_RUN;
      s_q.pc    <= PC_RST;
      s_q.flags <= FLAGS_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pmem_addr_o = s_q.pc;
  assign mem_req_o   = s_q.mem;
  assign io_req_o    = s_q.io;
  assign stack_req_o = s_q.stk;
  assign rf_rdata_o  = s_q.rf_rd;
  assign pc_o        = s_q.pc;
  assign flags_reg_o = s_q.flags;
  assign unsup_o     = s_q.unsup;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  property p_icall;                                          // RQ1
    (s_q.st == ST_RUN && ins == OP_EXT_INDIRECT_JSR) |=> stack_req_o.push
      && pc_o == {$past(far_target_high_byte_i[5:0]),
                  $past(s_q.rf[31]), $past(s_q.rf[30])}
      ##1 s_q.st == ST_WAIT ##1 s_q.st == ST_RUN;
  endproperty
  a_icall: assert property (p_icall)                         // RQ1
    else $error("indirect call target or timing wrong");

  property p_equal_compare_skip_ne;                                        // RQ2
    (s_q.st == ST_RUN && op_is(ins, MK_RR, OP_EQUAL_COMPARE_SKIP) && opa != opb)
      |=> s_q.st == ST_RUN && pc_o == $past(s_q.pc) + 22'h000001;
  endproperty
  a_equal_compare_skip_ne: assert property (p_equal_compare_skip_ne)                     // RQ2
    else $error("unequal compare skip did not fall through");

  property p_rbit;                                           // RQ3
    (s_q.st == ST_RUN && op_is(ins, MK_RBIT, OP_RBS)
     && s_q.rf[ins[8:4]][ins[2:0]] && !flags_we_i)
      |=> s_q.st == ST_SKIP1 && $stable(s_q.flags);
  endproperty
  a_rbit: assert property (p_rbit)                           // RQ3
    else $error("set-bit skip not started or flags moved");

  property p_iobit;                                          // RQ4
    (s_q.st == ST_RUN && op_is(ins, MK_IOBIT, OP_IOC))
      |=> io_req_o.rd && io_req_o.addr == $past(ins[7:3])
      ##1 s_q.st != ST_IOWAIT;
  endproperty
  a_iobit: assert property (p_iobit)                         // RQ4
    else $error("I/O skip read strobe or wait wrong");

  property p_br_taken;                                       // RQ5
    (s_q.st == ST_RUN && op_is(ins, MK_RR, OP_BRS) && flag_bit)
      |=> pc_o == $past(br_tgt) && s_q.st == ST_WAIT
      ##1 s_q.st == ST_RUN && $stable(pc_o);
  endproperty
  a_br_taken: assert property (p_br_taken)                   // RQ5
    else $error("taken branch target or timing wrong");

  property p_signed_ge;                                      // RQ7
    (s_q.st == ST_RUN && op_is(ins, MK_RR, OP_BRC)
     && ins[2:0] == FLAG_S
     && (s_q.flags[FLAG_N] ^ s_q.flags[FLAG_V]))
      |=> pc_o == $past(s_q.pc) + 22'h000001;
  endproperty
  a_signed_ge: assert property (p_signed_ge)                 // RQ7
    else $error("signed branch taken with N xor V set");

  property p_cmp;                                            // RQ14
    (s_q.st == ST_RUN && op_is(ins, MK_RR, OP_CP) && !rf_we_i)
      |=> $stable(s_q.rf) && s_q.flags[FLAG_Z] == ($past(opa)
          == $past(opb));
  endproperty
  a_cmp: assert property (p_cmp)                             // RQ14
    else $error("compare wrote a register or wrong zero flag");

  property p_lds;                                            // RQ13
    (s_q.st == ST_LDDATA && mem_ack_i && !flags_we_i)
      |=> s_q.rf[$past(s_q.ld_dst)] == $past(mem_rdata_i)
          && $stable(s_q.flags) && !mem_req_o.rd;
  endproperty
  a_lds: assert property (p_lds)                             // RQ13
    else $error("direct load byte not stored or flags moved");

  property p_irq_exit;                                           // RQ15
    (s_q.st == ST_RUN && ins == OP_IRQ_EXIT && !flags_we_i)
      |=> s_q.flags[FLAG_I] && stack_req_o.pop
      ##1 pc_o == $past(stack_rdata_i) ##2 s_q.st == ST_RUN;
  endproperty
  a_irq_exit: assert property (p_irq_exit)                           // RQ15
    else $error("interrupt return pop or enable wrong");

endmodule
`default_nettype wire

/* testbench/cpu_branch_skip_load_exec_test.sv */
// Self-checking bench for the flow execution unit.
// Assumes flow_exec_pkg and flow_exec are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cpu_branch_skip_load_exec_test;
  import flow_exec_pkg::*;
  // ****************************************
  // Signals and program image
  // ****************************************
  logic             mclk_i, sys_rst_i, mem_ack_i, rf_we_i, flags_we_i;
  logic             unsup_o;
  logic [PC_W-1:0]  pmem_addr_o, stack_rdata_i, pc_o;
  logic [15:0]      pmem_data_i;
  logic [7:0]       far_target_high_byte_i, mem_rdata_i, io_rdata_i;
  logic [7:0]       rf_wdata_i, rf_rdata_o, flags_wdata_i, flags_reg_o;
  logic [4:0]       rf_waddr_i, rf_raddr_i;
  mem_req_t         mem_req_o;
  io_req_t          io_req_o;
  stack_req_t       stack_req_o;
  logic [15:0]      prog [64];  // Words outside read as 0000
  logic [7:0]       pat [4] = '{8'h00, 8'hff, 8'h04, 8'h28};
  int               failures, tests_run;

  // Program memory answers in the same cycle
  assign pmem_data_i = (pmem_addr_o < 64) ? prog[pmem_addr_o[5:0]] : 16'h0;

  flow_exec uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .pmem_addr_o(pmem_addr_o), .pmem_data_i(pmem_data_i),
    .far_target_high_byte_i(far_target_high_byte_i),
    .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .io_req_o(io_req_o),
    .io_rdata_i(io_rdata_i), .stack_req_o(stack_req_o),
    .stack_rdata_i(stack_rdata_i), .rf_we_i(rf_we_i),
    .rf_waddr_i(rf_waddr_i), .rf_wdata_i(rf_wdata_i),
    .rf_raddr_i(rf_raddr_i), .rf_rdata_o(rf_rdata_o),
    .flags_we_i(flags_we_i), .flags_wdata_i(flags_wdata_i),
    .pc_o(pc_o), .flags_reg_o(flags_reg_o), .unsup_o(unsup_o));

  // 100 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Inputs move 1 ns after the edge, so outputs have settled too
  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // A wait that ran out is a hang: report and stop
  task automatic guard(input int n, input int lim);
    if (n >= lim)
    begin
      failures++;
      end_sim();
    end
  endtask

  // Three reset edges with an empty program
  task automatic rst();
    foreach (prog[i]) prog[i] = 16'h0000;
    sys_rst_i = 1'b1;
    repeat (3) tick();
    sys_rst_i = 1'b0;
  endtask

  // Two outside register writes while filler words execute; the
  // strobe stays up between them so it never drops and rises again
  // in one time step
  task automatic wr2(input logic [4:0] a1, input logic [7:0] d1,
                     input logic [4:0] a2, input logic [7:0] d2);
    rf_we_i = 1'b1;
    rf_waddr_i = a1;
    rf_wdata_i = d1;
    tick();
    rf_waddr_i = a2;
    rf_wdata_i = d2;
    tick();
    rf_we_i = 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Flag branch at word 1, offset 5, flags loaded by word 0
  task automatic branch(input logic clr, input logic [2:0] s,
                        input logic [7:0] f);
    logic take;
    take = ((s == FLAG_S) ? (f[2] ^ f[3]) : f[s]) ^ clr;
    rst();
    prog[1] = (clr ? OP_BRC : OP_BRS) | 16'h0028 | s;
    flags_we_i = 1'b1;
    flags_wdata_i = f;
    tick();
    flags_we_i = 1'b0;
    tick();
    chk(pc_o, take ? 32'h7 : 32'h2);
    chk(unsup_o, 1'b0);
    tick();
    chk(pc_o, take ? 32'h7 : 32'h3);
    chk(unsup_o, take ? 32'h0 : 32'h1);
    chk(flags_reg_o, f);
  endtask

  // r1=a, r2=b, opcode at word 2; cycles counted to the word after
  task automatic skip(input logic [15:0] ins, input logic [7:0] a,
                      input logic [7:0] b, input logic two,
                      input logic sk, input int base,
                      input logic [7:0] fl);
    int n;
    int tgt;
    tgt = 3 + (sk ? (two ? 2 : 1) : 0);
    rst();
    prog[2] = ins;
    prog[3] = two ? OP_LDS : 16'h0000;
    io_rdata_i = b;
    wr2(5'h01, a, 5'h02, b);
    n = 0;
    while (pc_o !== tgt[PC_W-1:0] + 1 && n < 12)
    begin
      tick();
      n++;
      if (io_req_o.rd === 1'b1) chk(io_req_o.addr, 5'h11);
      chk(mem_req_o.rd, 1'b0);
    end
    guard(n, 12);
    chk(n, base + tgt - 2);
    chk(flags_reg_o, fl);
  endtask

  // Direct load from 8123 with the acknowledge held back dly cycles
  task automatic load(input int dly);
    int n;
    int w;
    rst();
    prog[1] = OP_LDS | 16'h0050;
    prog[2] = 16'h8123;
    flags_we_i = 1'b1;
    flags_wdata_i = 8'ha5;
    tick();
    flags_we_i = 1'b0;
    n = 0;
    w = 0;
    while (mem_ack_i !== 1'b1 && n < 20)
    begin
      tick();
      n++;
      if (mem_req_o.rd === 1'b1)
      begin
        chk(mem_req_o.addr, 32'h8123);
        mem_ack_i = (w == dly);
        mem_rdata_i = (w == dly) ? 8'hc3 : 8'h3c;
        w++;
      end
    end
    guard(n, 20);
    tick();
    mem_ack_i = 1'b0;
    chk(n, 2 + dly);
    chk(mem_req_o.rd, 1'b0);
    rf_raddr_i = 5'h05;
    tick();
    chk(rf_rdata_o, 8'hc3);
    chk(flags_reg_o, 8'ha5);
  endtask

  // Far indirect call from word 2 through Z = 9234
  task automatic icall();
    rst();
    prog[2] = OP_EXT_INDIRECT_JSR;
    far_target_high_byte_i = 8'hc7;
    wr2(5'h1e, 8'h34, 5'h1f, 8'h92);
    tick();
    chk(pc_o, 32'h079234);
    chk(stack_req_o.push, 1'b1);
    chk(stack_req_o.wdata, 32'h3);
    tick();
    chk(stack_req_o.push, 1'b0);
    tick();
    chk(pc_o, 32'h079234);
    tick();
    chk(pc_o, 32'h079235);
  endtask

  // Return to word 10 from the stack
  task automatic ret(input logic irq);
    rst();
    prog[0] = irq ? OP_IRQ_EXIT : OP_RET;
    stack_rdata_i = 22'h000010;
    tick();
    chk(stack_req_o.pop, 1'b1);
    tick();
    chk(pc_o, 32'h10);
    chk(flags_reg_o[FLAG_I], irq);
    repeat (2) tick();
    chk(pc_o, 32'h10);
    tick();
    chk(pc_o, 32'h11);
  endtask

  initial
  begin
    failures = 0;
    tests_run = 0;
    foreach (prog[i]) prog[i] = 16'h0000;
    {mem_ack_i, rf_we_i, flags_we_i} = 3'h0;
    {far_target_high_byte_i, mem_rdata_i, io_rdata_i} = 24'h0;
    {rf_waddr_i, rf_wdata_i, rf_raddr_i, flags_wdata_i} = 26'h0;
    stack_rdata_i = 22'h0;
    for (int s = 0; s < 8; s++)
      for (int c = 0; c < 2; c++)
        foreach (pat[p]) branch(c[0], s[2:0], pat[p]);
    skip(16'h1012, 8'h5a, 8'h5a, 1'b0, 1'b1, 1, 8'h00);
    skip(16'h1012, 8'h5a, 8'h5b, 1'b0, 1'b0, 1, 8'h00);
    skip(16'h1012, 8'h5a, 8'h5a, 1'b1, 1'b1, 1, 8'h00);
    skip(16'hfc10, 8'h5a, 8'h00, 1'b0, 1'b1, 1, 8'h00);
    skip(16'hfe10, 8'h5a, 8'h00, 1'b0, 1'b0, 1, 8'h00);
    skip(16'hfe16, 8'h5a, 8'h00, 1'b1, 1'b1, 1, 8'h00);
    skip(16'h998b, 8'h00, 8'h08, 1'b0, 1'b0, 2, 8'h00);
    skip(16'h9b8b, 8'h00, 8'h08, 1'b1, 1'b1, 2, 8'h00);
    skip(16'h998a, 8'h00, 8'h08, 1'b0, 1'b1, 2, 8'h00);
    skip(16'h1412, 8'h05, 8'h06, 1'b0, 1'b0, 1, 8'h35);
    skip(16'h1412, 8'h5a, 8'h5a, 1'b0, 1'b0, 1, 8'h02);
    skip(16'h0412, 8'h5a, 8'h5a, 1'b0, 1'b0, 1, 8'h00);
    load(0);
    load(3);
    icall();
    ret(1'b0);
    ret(1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
